/* File: muting_override_control.sv */
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
// Behaviour
// R1: Flash request while muting off, sensor on, outputs off.
// R2: Qualified override pulse forces output enable active.
// R3: Pulse high 100 ms to 3 s; longer ignored.
// R4: Sensors clear and outputs active end override.
// R5: Further override allowed below the count limit.
// R6: Only muting 0, sensor on, outputs 0 qualify.
// R7: Limit is one hour over total muting time.
// R8: Total time up to 10 s allows 360.
// R9: Time 15 min or disabled allows 5.
// R10: Retained count advances with request-qualified overrides.
// R11: Count clears on cycle, reset, idle-to-executing.
// R12: Faulty-sensor stop gives one-cycle request.
// R13: Repeated sensor fault restarts request again.
// R14: Override suspends direction, sequence, concurrence checks.
// R15: Override input must not use test pulses.
// R16: Conveyor low holds muting timers.
// R17: Restart resumes timers with 3 s extra.
// R18: Status 1 during override; lamp flashes 2 Hz.
// R19: Width measured; short pulse changes nothing.
// R20: At limit, further pulses give no enable.
module muting_override_control #(
    parameter int unsigned TICK_CYCLES = muting_override_pkg::TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Muting core and field inputs
    input wire logic muting_status_i,
    input wire logic [3:0] muting_sensor_i,
    input wire logic safety_switch_outputs_i,
    input wire logic output_enable_i,
    input wire logic override_i,
    input wire logic conveyor_i,
    input wire logic sensor_fault_stop_i,
    input wire logic valid_cycle_done_i,
    input wire logic idle_to_exec_i,
    // Override results
    output logic override_request_o,
    output logic override_active_o,
    output logic output_enable_o,
    output logic muting_status_o,
    output logic muting_lamp_o,
    output logic checks_suspend_o,
    // Timer supervision
    output logic timers_hold_o,
    output logic tmt_expired_o,
    output logic conc_expired_o
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Seconds to milliseconds at timer width.
    function automatic logic [muting_override_pkg::MS_W-1:0] ms_of_s(
        input logic [muting_override_pkg::SEC_W-1:0] s
    );
        ms_of_s = muting_override_pkg::MS_W'(s * muting_override_pkg::MS_PER_S);
    endfunction

    // Allowed override cycles for a total muting time in seconds.
    function automatic logic [muting_override_pkg::CNT_W-1:0] cycle_limit(
        input logic [muting_override_pkg::SEC_W-1:0] s
    );
        if (s == '0 || s >= muting_override_pkg::SEC_W'(muting_override_pkg::TMT_HIGH_S)) begin
            cycle_limit = muting_override_pkg::CNT_W'(muting_override_pkg::LIM_HIGH_TMT); // R9
        end else if (s <= muting_override_pkg::SEC_W'(muting_override_pkg::TMT_LOW_S)) begin
            cycle_limit = muting_override_pkg::CNT_W'(muting_override_pkg::LIM_LOW_TMT); // R8
        end else begin
            cycle_limit = muting_override_pkg::CNT_W'(muting_override_pkg::HOUR_S / s); // R7
        end
    endfunction

    // Saturating timer step: hold, grace on restart, or count a tick.
    function automatic logic [muting_override_pkg::MS_W-1:0] timer_step(
        input logic [muting_override_pkg::MS_W-1:0] t,
        input logic run,
        input logic restart,
        input logic tick
    );
        logic [muting_override_pkg::MS_W-1:0] grace;
        grace = muting_override_pkg::MS_W'(muting_override_pkg::RESTART_GRACE_MS);
        if (restart) begin
            timer_step = (t > grace) ? t - grace : '0;
        end else if (run && tick && t != '1) begin
            timer_step = t + 1'b1;
        end else begin
            timer_step = t;
        end
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    muting_override_pkg::ovr_state_t state_q;
    muting_override_pkg::ovr_state_t state_d;
    logic [muting_override_pkg::TICK_W-1:0] tick_cnt_q;
    logic [muting_override_pkg::MS_W-1:0] high_ms_q;
    logic [muting_override_pkg::MS_W-1:0] flash_ms_q;
    logic [muting_override_pkg::MS_W-1:0] tmt_ms_q;
    logic [muting_override_pkg::MS_W-1:0] conc_ms_q;
    logic [muting_override_pkg::SEC_W-1:0] tmt_cfg_q;
    logic [muting_override_pkg::SEC_W-1:0] conc_cfg_q;
    logic [muting_override_pkg::CNT_W-1:0] limit_q;
    logic [muting_override_pkg::CNT_W-1:0] count;
    logic flash_q;
    logic override_q;
    logic conveyor_q;
    logic soft_clear_q;
    logic tick;
    logic sensor_any;
    logic request_cond;
    logic override_rise;
    logic override_fall;
    logic width_ok;
    logic too_long;
    logic limit_hit;
    logic accept;
    logic cycle_end;
    logic count_clear;
    logic conv_restart;
    logic pair_mismatch;
    logic wb_req;
    logic wb_wr;
    logic [31:0] rd_data;

    // ****************************************************************
    // Millisecond time base and input edges
    // ****************************************************************

    // Every long time is counted in 1 ms ticks to keep counters narrow.
    assign tick = (tick_cnt_q == muting_override_pkg::TICK_W'(TICK_CYCLES - 1));
    assign override_rise = override_i & ~override_q;
    assign override_fall = ~override_i & override_q;
    assign conv_restart = conveyor_i & ~conveyor_q;

    // Tick divider and edge history.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_q <= '0;
            override_q <= 1'b0;
            conveyor_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
            override_q <= override_i;
            conveyor_q <= conveyor_i;
        end
    end

    // ****************************************************************
    // Override request and acceptance
    // ****************************************************************

    // Only muting off, a sensor on, switch outputs off and enable off qualify.
    assign sensor_any = |muting_sensor_i;
    assign request_cond = ~muting_status_i & sensor_any & ~safety_switch_outputs_i
        & ~output_enable_i & (state_q != muting_override_pkg::OVR_ACTIVE); // R1 R6
    assign width_ok = (high_ms_q >= muting_override_pkg::MS_W'(muting_override_pkg::OVR_MIN_MS))
        & (high_ms_q <= muting_override_pkg::MS_W'(muting_override_pkg::OVR_MAX_MS)); // R3 R19
    assign too_long = high_ms_q > muting_override_pkg::MS_W'(muting_override_pkg::OVR_MAX_MS);
    assign limit_hit = (count >= limit_q); // R20
    assign accept = (state_q == muting_override_pkg::OVR_HIGH) & override_fall & width_ok
        & request_cond & ~limit_hit; // R2 R5
    assign cycle_end = ~sensor_any & safety_switch_outputs_i; // R4
    assign count_clear = valid_cycle_done_i | soft_clear_q | idle_to_exec_i; // R11

    // Request flashes at 2 Hz; a faulty-sensor stop adds a one-cycle request.
    assign override_request_o = request_cond & (flash_q | sensor_fault_stop_i); // R1 R12 R13

    // Pulse state machine: measure, qualify, hold the override cycle.
    always_comb begin
        state_d = state_q;
        case (state_q)
            muting_override_pkg::OVR_IDLE: begin
                if (override_rise) begin
                    state_d = muting_override_pkg::OVR_HIGH;
                end
            end
            muting_override_pkg::OVR_HIGH: begin
                if (accept) begin
                    state_d = muting_override_pkg::OVR_ACTIVE; // R2
                end else if (override_fall) begin
                    state_d = muting_override_pkg::OVR_IDLE; // R19 R20
                end else if (too_long) begin
                    state_d = muting_override_pkg::OVR_IGNORE; // R3
                end
            end
            muting_override_pkg::OVR_IGNORE: begin
                if (~override_i) begin
                    state_d = muting_override_pkg::OVR_IDLE;
                end
            end
            muting_override_pkg::OVR_ACTIVE: begin
                if (cycle_end) begin
                    state_d = muting_override_pkg::OVR_IDLE; // R4
                end
            end
            default: begin
                state_d = muting_override_pkg::OVR_IDLE;
            end
        endcase
        if (idle_to_exec_i) begin
            state_d = muting_override_pkg::OVR_IDLE;
        end
    end

    // State, pulse width, and 2 Hz flash phase.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= muting_override_pkg::OVR_IDLE;
            high_ms_q <= '0;
            flash_ms_q <= '0;
            flash_q <= 1'b0;
        end else begin
            state_q <= state_d;
            high_ms_q <= override_rise ? '0 : timer_step(high_ms_q, override_i, 1'b0, tick);
            if (~request_cond) begin
                flash_ms_q <= '0;
                flash_q <= 1'b0;
            end else if (tick) begin
                if (flash_ms_q == muting_override_pkg::MS_W'(muting_override_pkg::FLASH_HALF_MS - 1)) begin
                    flash_ms_q <= '0;
                    flash_q <= ~flash_q;
                end else begin
                    flash_ms_q <= flash_ms_q + 1'b1;
                end
            end
        end
    end

    // Retained count of used override cycles.
    override_count_store u_count (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(count_clear),
        .incr_i(accept),
        .count_o(count)
    ); // R10 R11

    // ****************************************************************
    // Outputs towards the muting core
    // ****************************************************************
    assign override_active_o = (state_q == muting_override_pkg::OVR_ACTIVE);
    assign output_enable_o = output_enable_i | override_active_o; // R2
    assign muting_status_o = muting_status_i | override_active_o; // R18
    assign muting_lamp_o = muting_status_o | override_request_o; // R18
    assign checks_suspend_o = override_active_o; // R14

    // ****************************************************************
    // Muting timers held while the conveyor stands
    // ****************************************************************
    assign timers_hold_o = ~conveyor_i; // R16
    assign pair_mismatch = (muting_sensor_i[0] ^ muting_sensor_i[1])
        | (muting_sensor_i[2] ^ muting_sensor_i[3]);
    assign tmt_expired_o = (tmt_cfg_q != '0) & (tmt_ms_q >= ms_of_s(tmt_cfg_q));
    assign conc_expired_o = ~checks_suspend_o & (conc_cfg_q != '0)
        & (conc_ms_q >= ms_of_s(conc_cfg_q)); // R14

    // Total muting and concurrence timers; restart grants extra time.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmt_ms_q <= '0;
            conc_ms_q <= '0;
        end else begin
            tmt_ms_q <= ~muting_status_o ? '0
                : timer_step(tmt_ms_q, conveyor_i, conv_restart, tick); // R16 R17
            conc_ms_q <= ~pair_mismatch ? '0
                : timer_step(conc_ms_q, conveyor_i, conv_restart, tick); // R16 R17
        end
    end

    // ****************************************************************
    // Wishbone register file
    // ****************************************************************
    assign wb_req = cyc_i & stb_i & ~ack_o;
    assign wb_wr = cyc_i & stb_i & we_i & ack_o;
    assign rd_data = (adr_i == muting_override_pkg::CFG_OFS)
        ? {4'h0, conc_cfg_q, 4'h0, tmt_cfg_q}
        : (adr_i == muting_override_pkg::STAT_OFS)
        ? {26'h0, conc_expired_o, tmt_expired_o, timers_hold_o, limit_hit,
           override_request_o, override_active_o}
        : (adr_i == muting_override_pkg::COUNT_OFS)
        ? {7'h00, limit_q, 7'h00, count}
        : 32'h0000_0000;

    // Bus answer one cycle after the request; writes land with the ack.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            tmt_cfg_q <= muting_override_pkg::CFG_TMT_RST;
            conc_cfg_q <= muting_override_pkg::CFG_CONC_RST;
            soft_clear_q <= 1'b0;
        end else begin
            ack_o <= wb_req;
            dat_o <= wb_req ? rd_data : 32'h0000_0000;
            soft_clear_q <= wb_wr & sel_i[0] & (adr_i == muting_override_pkg::CMD_OFS)
                & dat_i[muting_override_pkg::CMD_CLEAR_BIT]; // R11
            if (wb_wr && adr_i == muting_override_pkg::CFG_OFS) begin
                if (sel_i[0]) tmt_cfg_q[7:0] <= dat_i[7:0];
                if (sel_i[1]) tmt_cfg_q[11:8] <= dat_i[11:8];
                if (sel_i[2]) conc_cfg_q[7:0] <= dat_i[23:16];
                if (sel_i[3]) conc_cfg_q[11:8] <= dat_i[27:24];
            end
        end
    end

    // Allowed cycle count follows the configured total muting time.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            limit_q <= cycle_limit(muting_override_pkg::CFG_TMT_RST);
        end else begin
            limit_q <= cycle_limit(tmt_cfg_q); // R7 R8 R9
        end
    end

endmodule

/* File: muting_override_pkg.sv */
package muting_override_pkg;

    // ****************************************************************
    // Clock and time base
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned TICK_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 18;

    // ****************************************************************
    // Override timing in milliseconds
    // ****************************************************************
    localparam int unsigned OVR_MIN_MS = 100;
    localparam int unsigned OVR_MAX_MS = 3000;
    localparam int unsigned FLASH_HALF_MS = 250;
    localparam int unsigned RESTART_GRACE_MS = 3000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int MS_W = 22;

    // ****************************************************************
    // Override cycle limit
    // ****************************************************************
    localparam int unsigned HOUR_S = 3600;
    localparam int unsigned TMT_LOW_S = 10;
    localparam int unsigned TMT_HIGH_S = 900;
    localparam int unsigned LIM_LOW_TMT = 360;
    localparam int unsigned LIM_HIGH_TMT = 5;
    localparam int CNT_W = 9;
    localparam int SEC_W = 12;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] COUNT_OFS = 8'h08;
    localparam logic [7:0] CMD_OFS = 8'h0C;
    localparam int CFG_TMT_LSB = 0;
    localparam int CFG_CONC_LSB = 16;
    localparam logic [SEC_W-1:0] CFG_TMT_RST = 12'h005;
    localparam logic [SEC_W-1:0] CFG_CONC_RST = 12'h000;
    localparam int CMD_CLEAR_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_REQ_BIT = 1;
    localparam int STAT_LIMIT_BIT = 2;
    localparam int STAT_HOLD_BIT = 3;
    localparam int STAT_TMT_ERR_BIT = 4;
    localparam int STAT_CONC_ERR_BIT = 5;
    localparam int COUNT_LIM_LSB = 16;

    // ****************************************************************
    // Override pulse state machine
    // ****************************************************************
    typedef enum logic [1:0] {
        OVR_IDLE,
        OVR_HIGH,
        OVR_IGNORE,
        OVR_ACTIVE
    } ovr_state_t;

endpackage

/* File: override_count_store.sv */
`timescale 1ns/100ps
// ********************************************************************
// Retained override cycle counter with registered read data
// ********************************************************************
module override_count_store (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Update controls
    input wire logic clear_i,
    input wire logic incr_i,
    // Read data
    output logic [muting_override_pkg::CNT_W-1:0] count_o
);

    logic [muting_override_pkg::CNT_W-1:0] cnt_q;
    logic [muting_override_pkg::CNT_W-1:0] cnt_d;

    // Clear wins over increment so a clearing event always restarts the budget.
    assign cnt_d = clear_i ? '0 : (incr_i ? cnt_q + 1'b1 : cnt_q);

    // Stored count and its registered copy for readers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            count_o <= '0;
        end else begin
            cnt_q <= cnt_d;
            count_o <= cnt_d;
        end
    end

endmodule

/* File: mo_check_props.sv */
`timescale 1ns/100ps
// ********************************************************************
// Port checker for the override block
// ********************************************************************
module mo_check #(
    parameter int unsigned TICK_CYCLES = 10
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Field and core inputs
    input wire logic muting_status_i,
    input wire logic [3:0] muting_sensor_i,
    input wire logic safety_switch_outputs_i,
    input wire logic output_enable_i,
    input wire logic override_i,
    input wire logic conveyor_i,
    input wire logic sensor_fault_stop_i,
    input wire logic idle_to_exec_i,
    // Results
    input wire logic override_request_o,
    input wire logic override_active_o,
    input wire logic output_enable_o,
    input wire logic muting_status_o,
    input wire logic muting_lamp_o,
    input wire logic checks_suspend_o,
    input wire logic timers_hold_o
);
    localparam int MINC = (muting_override_pkg::OVR_MIN_MS - 1) * TICK_CYCLES;
    localparam int MAXC = (muting_override_pkg::OVR_MAX_MS + 1) * TICK_CYCLES;
    int hi_q;
    int w_q;
    logic ovr_q;
    wire logic req_ok = !muting_status_i && |muting_sensor_i && !safety_switch_outputs_i
        && !output_enable_i;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Measures the last press width in clocks, latched on release.
    always_ff @(posedge clk_i) begin
        ovr_q <= override_i;
        hi_q <= (rst_i || !override_i) ? 0 : hi_q + 1;
        w_q <= rst_i ? 0 : ((ovr_q && !override_i) ? hi_q : w_q);
    end

    a_req_qualify: assert property (
        override_request_o |-> req_ok) else $error("request without its conditions");
    a_fault_req: assert property (
        sensor_fault_stop_i && req_ok && !override_active_o |-> override_request_o)
        else $error("fault stop gave no request");
    a_width_ok: assert property (
        $rose(override_active_o) |-> w_q >= MINC && w_q <= MAXC && !override_i)
        else $error("override started on a bad press");
    a_oe_force: assert property (
        output_enable_o == (output_enable_i || override_active_o)) else $error("enable wrong");
    a_ovr_end: assert property (
        override_active_o && muting_sensor_i == 4'h0 && safety_switch_outputs_i |=>
        !override_active_o) else $error("override did not end");
    a_exec_abort: assert property (
        idle_to_exec_i |=> !override_active_o) else $error("override kept after exec start");
    a_status_ovr: assert property (
        override_active_o |-> muting_status_o && checks_suspend_o && !override_request_o)
        else $error("status wrong in override");
    a_lamp_show: assert property (
        muting_lamp_o == (muting_status_o || override_request_o)) else $error("lamp wrong");
    a_hold_conv: assert property (
        timers_hold_o == !conveyor_i) else $error("timer hold wrong");
    a_ack_once: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");

    c_ovr: cover property ($rose(override_active_o));
    c_fault: cover property (sensor_fault_stop_i && override_request_o);
    c_ack: cover property (ack_o);
endmodule

bind muting_override_control mo_check #(.TICK_CYCLES(TICK_CYCLES)) u_check (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .muting_status_i(muting_status_i), .muting_sensor_i(muting_sensor_i),
    .safety_switch_outputs_i(safety_switch_outputs_i), .output_enable_i(output_enable_i),
    .override_i(override_i), .conveyor_i(conveyor_i), .sensor_fault_stop_i(sensor_fault_stop_i),
    .idle_to_exec_i(idle_to_exec_i), .override_request_o(override_request_o),
    .override_active_o(override_active_o), .output_enable_o(output_enable_o),
    .muting_status_o(muting_status_o), .muting_lamp_o(muting_lamp_o),
    .checks_suspend_o(checks_suspend_o), .timers_hold_o(timers_hold_o));

/* File: field_model.sv */
`timescale 1ns/100ps
// ********************************************************************
// Sensors, light curtain, pushbutton and conveyor
// ********************************************************************
module field_model #(
    parameter int unsigned TICK_CYCLES = 10
) (
    // Clock
    input wire logic clk_i,
    // Field signals
    output logic [3:0] muting_sensor_o,
    output logic safety_switch_outputs_o,
    output logic override_o,
    output logic conveyor_o
);
    // Idle field: nothing in the path, curtain clear, conveyor moving.
    initial begin
        muting_sensor_o = 4'h0;
        safety_switch_outputs_o = 1'b1;
        override_o = 1'b0;
        conveyor_o = 1'b1;
    end

    // Places an object in front of the sensors and the curtain.
    task automatic place(input logic [3:0] s, input logic clear);
        @(posedge clk_i);
        muting_sensor_o <= s;
        safety_switch_outputs_o <= clear;
    endtask

    // A plain level press with no test pulses on the button line.
    task automatic press(input int ms);
        @(posedge clk_i);
        override_o <= 1'b1;
        repeat (ms * TICK_CYCLES) @(posedge clk_i);
        override_o <= 1'b0;
    endtask

    // Starts or stops the conveyor.
    task automatic conv(input logic v);
        @(posedge clk_i);
        conveyor_o <= v;
    endtask
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
// ********************************************************************
// Self-checking bench for the override block
// ********************************************************************
module tb;
    localparam int unsigned TK = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, ms_i = 1'b0, oe_i = 1'b0, flt_i = 1'b0, vcd_i = 1'b0, ite_i = 1'b0;
    logic [3:0] sens;
    logic ssw, ovr_i, conv_i, req_o, act_o, oe_o, mst_o, lamp_o, sus_o, hold_o, tmt_o, conc_o;
    int errors = 0, checks = 0, mcount = 0, n, seed;
    int cfgs[$] = '{0, 20, 10, 900, 899, 11};

    // Clock of 4 ns.
    always #2 clk_i = ~clk_i;

    field_model #(.TICK_CYCLES(TK)) fld (.clk_i(clk_i), .muting_sensor_o(sens),
        .safety_switch_outputs_o(ssw), .override_o(ovr_i), .conveyor_o(conv_i));
    muting_override_control #(.TICK_CYCLES(TK)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .muting_status_i(ms_i), .muting_sensor_i(sens),
        .safety_switch_outputs_i(ssw), .output_enable_i(oe_i), .override_i(ovr_i),
        .conveyor_i(conv_i), .sensor_fault_stop_i(flt_i), .valid_cycle_done_i(vcd_i),
        .idle_to_exec_i(ite_i), .override_request_o(req_o), .override_active_o(act_o),
        .output_enable_o(oe_o), .muting_status_o(mst_o), .muting_lamp_o(lamp_o),
        .checks_suspend_o(sus_o), .timers_hold_o(hold_o), .tmt_expired_o(tmt_o),
        .conc_expired_o(conc_o));

    // Allowed override cycles for a total muting time in seconds.
    function automatic int lim(input int t);
        if (t == 0 || t >= 900) return 5;
        if (t <= 10) return 360;
        return 3600 / t;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One classic bus cycle; read data is taken at the ack edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {1'b1, 1'b1, w, a, d, 4'hF};
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++k < 50);
        if (k >= 50) chk(ack_o, 1'b1);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask

    // Offers an object for override, presses, checks and clears the path.
    task automatic ovr(input int ms, input logic exp);
        fld.place(4'h1, 1'b0);
        fld.press(ms);
        repeat (3) @(posedge clk_i);
        chk(act_o, exp);
        chk(oe_o & mst_o & sus_o, exp);
        if (exp) mcount++;
        wb(0, muting_override_pkg::COUNT_OFS, 0);
        chk(rd[8:0], mcount);
        fld.place(4'h0, 1'b1);
        repeat (2) @(posedge clk_i);
        chk(act_o, 1'b0);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        #(90000 * 4);
        errors++;
        finish_test();
    end

    // Main sequence.
    initial begin
        seed = $urandom(32'h53C987D3);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, muting_override_pkg::CFG_OFS, 0);
        chk(rd, 32'h0000_0005);
        wb(1, muting_override_pkg::STAT_OFS, 32'hFFFF_FFFF);
        wb(0, muting_override_pkg::COUNT_OFS, 0);
        chk(rd, 32'h0168_0000);
        wb(0, 8'h40, 0);
        chk(rd, 32'h0);
        for (int i = 0; i < 16; i++) begin
            {oe_i, ms_i} <= {i[3], i[0]};
            fld.place({3'b000, i[1]}, i[2]);
            flt_i <= 1'b1;
            @(posedge clk_i);
            chk(req_o, i == 2);
            flt_i <= 1'b0;
        end
        {oe_i, ms_i} <= 2'b00;
        fld.place(4'h1, 1'b0);
        repeat (10) @(posedge clk_i);
        n = 0;
        repeat (5000) begin
            @(posedge clk_i);
            n += (req_o === 1'b1);
        end
        chk(n, 2500);
        ovr(50, 1'b0);
        ovr(3100, 1'b0);
        ovr(110 + $urandom % 90, 1'b1);
        wb(1, muting_override_pkg::CFG_OFS, 0);
        repeat (5) ovr(110 + $urandom % 90, mcount < 5);
        wb(0, muting_override_pkg::STAT_OFS, 0);
        chk(rd[2], 1'b1);
        wb(1, muting_override_pkg::CMD_OFS, 1);
        mcount = 0;
        wb(0, muting_override_pkg::COUNT_OFS, 0);
        chk(rd, 32'h0005_0000);
        for (int k = 0; k < 2; k++) begin
            ovr(120, 1'b1);
            {ite_i, vcd_i} <= k ? 2'b10 : 2'b01;
            @(posedge clk_i);
            {ite_i, vcd_i} <= 2'b00;
            mcount = 0;
            wb(0, muting_override_pkg::COUNT_OFS, 0);
            chk(rd[8:0], 0);
        end
        foreach (cfgs[j]) begin
            wb(1, muting_override_pkg::CFG_OFS, cfgs[j]);
            wb(0, muting_override_pkg::COUNT_OFS, 0);
            chk(rd[24:16], lim(cfgs[j]));
        end
        wb(1, muting_override_pkg::CFG_OFS, 32'h0001_0001);
        ms_i <= 1'b1;
        fld.place(4'h1, 1'b0);
        repeat (9000) @(posedge clk_i);
        fld.conv(1'b0);
        @(posedge clk_i);
        chk(hold_o, 1'b1);
        repeat (2000) @(posedge clk_i);
        fld.conv(1'b1);
        repeat (9000) @(posedge clk_i);
        chk({tmt_o, conc_o}, 2'b00);
        repeat (2000) @(posedge clk_i);
        chk({tmt_o, conc_o, lamp_o}, 3'b111);
        finish_test();
    end
endmodule
